//--- design/tmr_defines.svh
/*
  Register offsets, field positions, reset values and divider counts of the
  dual timer/counter block.
  Assumes byte addressing on a 32-bit register bus, one register per word.
*/
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define TMR_ADR_W 12
`define TMR_OFS_CTRL 12'h410
`define TMR_OFS_MODE 12'h414
`define TMR_OFS_OSTAT 12'h418
`define TMR_OFS_CNT0 12'h420
`define TMR_OFS_CNT1 12'h424
`define TMR_OFS_RLD0 12'h428
`define TMR_OFS_RLD1 12'h42c
`define TMR_OFS_SCFG 12'h440

// ----------------------------------------------------------------------
// Control and flag register fields
// ----------------------------------------------------------------------
`define TMR_CTRL_TF1 7
`define TMR_CTRL_TR1 6
`define TMR_CTRL_TF0 5
`define TMR_CTRL_TR0 4
`define TMR_CTRL_IE1 3
`define TMR_CTRL_IT1 2
`define TMR_CTRL_IE0 1
`define TMR_CTRL_IT0 0

// ----------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------
`define TMR_MODE_TIMER_ZERO_GATE 7
`define TMR_MODE_SEL0 6
`define TMR_MODE_MD0_HI 5
`define TMR_MODE_MD0_LO 4
`define TMR_MODE_GATE1 3
`define TMR_MODE_SEL1 2
`define TMR_MODE_MD1_HI 1
`define TMR_MODE_MD1_LO 0

// ----------------------------------------------------------------------
// Output status and system configuration fields
// ----------------------------------------------------------------------
`define TMR_OSTAT_TOE0 0
`define TMR_OSTAT_TOE1 2
`define TMR_OSTAT_MASK 8'h05
`define TMR_SCFG_PS_HI 3
`define TMR_SCFG_PS_LO 2
`define TMR_SCFG_MASK 8'h0f

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define TMR_RST_BYTE 8'h00
`define TMR_RST_WORD 16'h0000
`define TMR_CNT16_MAX 16'hffff
`define TMR_CNT8_MAX 8'hff
`define TMR_DIV4_M1 6'h03
`define TMR_DIV16_M1 6'h0f
`define TMR_DIV64_M1 6'h3f

`endif

//--- design/tmr_pkg.sv
/*
  Types of the dual timer/counter block: operating modes and the state
  records of each module.
  Assumes tmr_defines.svh for all numeric constants.
*/
package tmr_pkg;

  typedef enum logic [1:0] {
    TMR_RELOAD16,
    TMR_FREE16,
    TMR_RELOAD8,
    TMR_SPLIT
  } tmr_mode_t;

  typedef struct packed {
    logic [5:0] cnt;
    logic tick;
  } tmr_presc_st_t;

  typedef struct packed {
    logic phase;
    logic [1:0] samp;
    logic [1:0] fall;
  } tmr_edge_st_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] ostat;
    logic [7:0] scfg;
    logic [15:0] cnt0;
    logic [15:0] cnt1;
    logic [15:0] rld0;
    logic [15:0] rld1;
    logic [1:0] pin_prev;
    logic [1:0] ext_req;
    logic baud_tick;
    logic ack;
    logic [31:0] dat;
  } tmr_core_st_t;

endpackage : tmr_pkg

//--- design/tmr_tick_if.sv
/*
  Carrier of the time-base tick and the count pin falling-edge pulses
  from the prescaler and the pin sampler to the timer core.
  Assumes all three modules share clk_sys.
*/
`timescale 1ns/1ps
interface tmr_tick_if;
  logic tick;
  logic [1:0] pin_fall;
  modport presc (output tick);
  modport sampler (output pin_fall);
  modport core (input tick, input pin_fall);
endinterface : tmr_tick_if

//--- design/tmr_presc.sv
/*
  Shared prescaler: one-cycle tick every 4, 16 or 64 clocks.
  Assumes clk_sys is the oscillator and prescale_sel comes from a register.
*/
`timescale 1ns/1ps
`include "tmr_defines.svh"
module tmr_presc
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic [1:0] prescale_sel,
  // Tick out
  tmr_tick_if.presc tk
);
  tmr_presc_st_t st;
  tmr_presc_st_t next_st;
  logic [5:0] div_m1;
  logic div_ok;

  always_comb begin
    next_st = st;
    div_ok = 1'b1;
    unique case (prescale_sel)
      2'b00: div_m1 = `TMR_DIV4_M1;
      2'b01: div_m1 = `TMR_DIV16_M1;
      2'b10: div_m1 = `TMR_DIV64_M1;
      2'b11: begin
        div_m1 = `TMR_DIV64_M1;
        div_ok = 1'b0;
      end
    endcase
    next_st.tick = div_ok && (st.cnt >= div_m1);
    if (!div_ok || st.cnt >= div_m1) begin
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + 6'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tk.tick = st.tick;

  AST_PRESC_RESERVED: assert property (@(posedge clk_sys) disable iff (rst)
    (prescale_sel == 2'b11) ##1 (prescale_sel == 2'b11) |-> !st.tick)
    else $error("tick while prescale code is reserved");
  AST_PRESC_DIV4: assert property (@(posedge clk_sys) disable iff (rst)
    st.tick ##1 (prescale_sel == 2'b00)[*4] |-> st.tick)
    else $error("divide-by-4 tick not every 4 clocks");
endmodule : tmr_presc

//--- design/tmr_pin_sampler.sv
/*
  Count pin sampler: samples both count pins every second clock and
  pulses on a high-to-low change between samples.
  Assumes the pins are synchronous to clk_sys.
*/
`timescale 1ns/1ps
`include "tmr_defines.svh"
module tmr_pin_sampler
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Count pins
  input wire logic [1:0] count_pin,
  // Edge pulses out
  tmr_tick_if.sampler tk
);
  tmr_edge_st_t st;
  tmr_edge_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.phase = !st.phase;
    next_st.fall = '0;
    if (st.phase) begin
      next_st.samp = count_pin;
      next_st.fall = st.samp & ~count_pin;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tk.pin_fall = st.fall;

  AST_PIN_FALL_SPACING: assert property (@(posedge clk_sys) disable iff (rst)
    st.fall[0] |=> !st.fall[0])
    else $error("count pin edge pulse longer than one clock");
endmodule : tmr_pin_sampler

//--- design/tmr_dual_timer.sv
/*
  Dual 16-bit timer/counter core with its registers on classic Wishbone.
  Assumes pins and vector acknowledges are synchronous to clk_sys, and that
  clk_sys is the oscillator clock.
*/
`timescale 1ns/1ps
`include "tmr_defines.svh"
module tmr_dual_timer
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`TMR_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins
  input wire logic t0_count_pin,
  input wire logic t1_count_pin,
  input wire logic ext_irq_zero_pin,
  input wire logic ext_irq_one_pin,
  // Interrupt vector acknowledges
  input wire logic irq_vec_t0,
  input wire logic irq_vec_t1,
  input wire logic irq_vec_ext0,
  input wire logic irq_vec_ext1,
  // Status out
  output logic timer_zero_overflow_flag,
  output logic timer_one_overflow_flag,
  output logic ext_irq_zero_req,
  output logic ext_irq_one_req,
  output logic t1_baud_tick,
  output logic tbase_tick
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic adr_hit(input logic [`TMR_ADR_W-1:0] adr,
                                   input logic [`TMR_ADR_W-1:0] ofs);
    adr_hit = (adr[`TMR_ADR_W-1:2] == ofs[`TMR_ADR_W-1:2]);
  endfunction : adr_hit

  // One count step: {overflow, new count}
  function automatic logic [16:0] tmr_step(input tmr_mode_t md,
                                           input logic [15:0] cnt,
                                           input logic [15:0] rld);
    unique case (md)
      TMR_RELOAD16: tmr_step = (cnt == `TMR_CNT16_MAX) ? {1'b1, rld}
                                                       : {1'b0, cnt + 16'h0001};
      TMR_FREE16: tmr_step = {cnt == `TMR_CNT16_MAX, cnt + 16'h0001};
      TMR_RELOAD8: tmr_step = (cnt[7:0] == `TMR_CNT8_MAX)
                              ? {1'b1, cnt[15:8], rld[7:0]}
                              : {1'b0, cnt[15:8], cnt[7:0] + 8'h01};
      TMR_SPLIT: tmr_step = {cnt[7:0] == `TMR_CNT8_MAX, cnt[15:8],
                             cnt[7:0] + 8'h01};
    endcase
  endfunction : tmr_step

  // ----------------------------------------------------------------------
  // Time base and pin sampling
  // ----------------------------------------------------------------------
  tmr_tick_if tk ();
  tmr_core_st_t st;
  tmr_core_st_t next_st;

  tmr_presc u_presc (
    .clk_sys(clk_sys),
    .rst(rst),
    .prescale_sel(st.scfg[`TMR_SCFG_PS_HI:`TMR_SCFG_PS_LO]),
    .tk(tk.presc)
  );

  tmr_pin_sampler u_sampler (
    .clk_sys(clk_sys),
    .rst(rst),
    .count_pin({t1_count_pin, t0_count_pin}),
    .tk(tk.sampler)
  );

  // ----------------------------------------------------------------------
  // Core logic
  // ----------------------------------------------------------------------
  tmr_mode_t md0;
  tmr_mode_t md1;
  logic split;
  logic inc0;
  logic inc1;
  logic hi_inc;
  logic ovf0;
  logic ovf1;
  logic ovf_hi;
  logic wr_now;
  logic [16:0] s0;
  logic [16:0] s1;
  logic [7:0] ctl;

  always_comb begin
    next_st = st;
    md0 = tmr_mode_t'(st.mode[`TMR_MODE_MD0_HI:`TMR_MODE_MD0_LO]);
    md1 = tmr_mode_t'(st.mode[`TMR_MODE_MD1_HI:`TMR_MODE_MD1_LO]);
    split = (md0 == TMR_SPLIT);
    wr_now = wb_cyc_i && wb_stb_i && wb_we_i && st.ack;
    // Run, gate and source select
    inc0 = st.ctrl[`TMR_CTRL_TR0]
           && (!st.mode[`TMR_MODE_TIMER_ZERO_GATE] || ext_irq_zero_pin)
           && (st.mode[`TMR_MODE_SEL0] ? tk.pin_fall[0] : tk.tick);
    // Split timer 0 owns the timer 1 run bit, so timer 1 runs without TR1, on its mode, gate and source select
    inc1 = (st.ctrl[`TMR_CTRL_TR1] || split) && (md1 != TMR_SPLIT)
           && (!st.mode[`TMR_MODE_GATE1] || ext_irq_one_pin)
           && (st.mode[`TMR_MODE_SEL1] ? tk.pin_fall[1] : tk.tick);
    hi_inc = split && st.ctrl[`TMR_CTRL_TR1] && tk.tick;
    s0 = tmr_step(md0, st.cnt0, st.rld0);
    s1 = tmr_step(md1, st.cnt1, st.rld1);
    ovf0 = inc0 && s0[16];
    ovf1 = inc1 && s1[16];
    ovf_hi = hi_inc && (st.cnt0[15:8] == `TMR_CNT8_MAX);
    if (inc0) begin
      next_st.cnt0 = s0[15:0];
    end
    if (hi_inc) begin
      next_st.cnt0[15:8] = st.cnt0[15:8] + 8'h01;
    end
    if (inc1) begin
      next_st.cnt1 = s1[15:0];
    end
    next_st.baud_tick = ovf1;
    // Flags: vector clears, then software write, then hardware set wins
    ctl = st.ctrl;
    ctl[`TMR_CTRL_TF0] = ctl[`TMR_CTRL_TF0] && !irq_vec_t0;
    ctl[`TMR_CTRL_TF1] = ctl[`TMR_CTRL_TF1] && !irq_vec_t1;
    ctl[`TMR_CTRL_IE0] = ctl[`TMR_CTRL_IE0] && !irq_vec_ext0;
    ctl[`TMR_CTRL_IE1] = ctl[`TMR_CTRL_IE1] && !irq_vec_ext1;
    if (wr_now && wb_sel_i[0] && adr_hit(wb_adr_i, `TMR_OFS_CTRL)) begin
      ctl = wb_dat_i[7:0];
    end
    if (ovf0 && !st.ostat[`TMR_OSTAT_TOE0]) begin
      ctl[`TMR_CTRL_TF0] = 1'b1;
    end
    if ((split ? ovf_hi : ovf1) && !st.ostat[`TMR_OSTAT_TOE1]) begin
      ctl[`TMR_CTRL_TF1] = 1'b1;
    end
    if (st.ctrl[`TMR_CTRL_IT0] && st.pin_prev[0] && !ext_irq_zero_pin) begin
      ctl[`TMR_CTRL_IE0] = 1'b1;
    end
    if (st.ctrl[`TMR_CTRL_IT1] && st.pin_prev[1] && !ext_irq_one_pin) begin
      ctl[`TMR_CTRL_IE1] = 1'b1;
    end
    next_st.ctrl = ctl;
    next_st.pin_prev = {ext_irq_one_pin, ext_irq_zero_pin};
    next_st.ext_req[0] = ctl[`TMR_CTRL_IT0] ? ctl[`TMR_CTRL_IE0] : !ext_irq_zero_pin;
    next_st.ext_req[1] = ctl[`TMR_CTRL_IT1] ? ctl[`TMR_CTRL_IE1] : !ext_irq_one_pin;
    // Register writes override counting
    if (wr_now && wb_sel_i[0]) begin
      if (adr_hit(wb_adr_i, `TMR_OFS_MODE)) next_st.mode = wb_dat_i[7:0];
      if (adr_hit(wb_adr_i, `TMR_OFS_OSTAT)) next_st.ostat = wb_dat_i[7:0] & `TMR_OSTAT_MASK;
      if (adr_hit(wb_adr_i, `TMR_OFS_SCFG)) next_st.scfg = wb_dat_i[7:0] & `TMR_SCFG_MASK;
      if (adr_hit(wb_adr_i, `TMR_OFS_CNT0)) next_st.cnt0[7:0] = wb_dat_i[7:0];
      if (adr_hit(wb_adr_i, `TMR_OFS_CNT1)) next_st.cnt1[7:0] = wb_dat_i[7:0];
      if (adr_hit(wb_adr_i, `TMR_OFS_RLD0)) next_st.rld0[7:0] = wb_dat_i[7:0];
      if (adr_hit(wb_adr_i, `TMR_OFS_RLD1)) next_st.rld1[7:0] = wb_dat_i[7:0];
    end
    if (wr_now && wb_sel_i[1]) begin
      if (adr_hit(wb_adr_i, `TMR_OFS_CNT0)) next_st.cnt0[15:8] = wb_dat_i[15:8];
      if (adr_hit(wb_adr_i, `TMR_OFS_CNT1)) next_st.cnt1[15:8] = wb_dat_i[15:8];
      if (adr_hit(wb_adr_i, `TMR_OFS_RLD0)) next_st.rld0[15:8] = wb_dat_i[15:8];
      if (adr_hit(wb_adr_i, `TMR_OFS_RLD1)) next_st.rld1[15:8] = wb_dat_i[15:8];
    end
    // Bus answer: ack one cycle after request, read data with it
    next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
    next_st.dat = '0;
    if (wb_cyc_i && wb_stb_i && !st.ack && !wb_we_i) begin
      if (adr_hit(wb_adr_i, `TMR_OFS_CTRL)) next_st.dat[7:0] = st.ctrl;
      if (adr_hit(wb_adr_i, `TMR_OFS_MODE)) next_st.dat[7:0] = st.mode;
      if (adr_hit(wb_adr_i, `TMR_OFS_OSTAT)) next_st.dat[7:0] = st.ostat;
      if (adr_hit(wb_adr_i, `TMR_OFS_SCFG)) next_st.dat[7:0] = st.scfg;
      if (adr_hit(wb_adr_i, `TMR_OFS_CNT0)) next_st.dat[15:0] = st.cnt0;
      if (adr_hit(wb_adr_i, `TMR_OFS_CNT1)) next_st.dat[15:0] = st.cnt1;
      if (adr_hit(wb_adr_i, `TMR_OFS_RLD0)) next_st.dat[15:0] = st.rld0;
      if (adr_hit(wb_adr_i, `TMR_OFS_RLD1)) next_st.dat[15:0] = st.rld1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign timer_zero_overflow_flag = st.ctrl[`TMR_CTRL_TF0];
  assign timer_one_overflow_flag = st.ctrl[`TMR_CTRL_TF1];
  assign ext_irq_zero_req = st.ext_req[0];
  assign ext_irq_one_req = st.ext_req[1];
  assign t1_baud_tick = st.baud_tick;
  assign tbase_tick = tk.tick;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_RELOAD16: assert property (
    inc0 && md0 == TMR_RELOAD16 && st.cnt0 == `TMR_CNT16_MAX && !wr_now
    |=> st.cnt0 == $past(st.rld0) && (st.ctrl[`TMR_CTRL_TF0] || st.ostat[`TMR_OSTAT_TOE0]))
    else $error("mode 0 overflow did not reload and flag");
  AST_FREE16_WRAP: assert property (
    inc1 && md1 == TMR_FREE16 && st.cnt1 == `TMR_CNT16_MAX && !wr_now |=> st.cnt1 == '0)
    else $error("mode 1 did not wrap to zero");
  AST_RELOAD8: assert property (
    inc0 && md0 == TMR_RELOAD8 && st.cnt0[7:0] == `TMR_CNT8_MAX && !wr_now
    |=> st.cnt0[7:0] == $past(st.rld0[7:0]) && st.cnt0[15:8] == $past(st.cnt0[15:8]))
    else $error("mode 2 reload wrong");
  AST_T1_HOLD: assert property (
    md1 == TMR_SPLIT && !wr_now |=> $stable(st.cnt1))
    else $error("timer 1 moved in mode 3");
  AST_SPLIT_HIGH: assert property (
    split && st.ctrl[`TMR_CTRL_TR1] && tk.tick && st.cnt0[15:8] == `TMR_CNT8_MAX
    && !st.ostat[`TMR_OSTAT_TOE1] && !wr_now |=> st.ctrl[`TMR_CTRL_TF1])
    else $error("split high byte overflow did not set timer 1 flag");
  AST_TOE_SUPPRESS: assert property (
    $rose(st.ctrl[`TMR_CTRL_TF0]) |-> $past(!st.ostat[`TMR_OSTAT_TOE0] || wr_now))
    else $error("timer 0 flag set while toggle output enabled");
  AST_VEC_CLEAR: assert property (
    irq_vec_t0 && !ovf0 && !wr_now |=> !st.ctrl[`TMR_CTRL_TF0])
    else $error("vector did not clear timer 0 flag");
  AST_EXT_EDGE: assert property (
    st.ctrl[`TMR_CTRL_IT0] && st.pin_prev[0] && !ext_irq_zero_pin && !wr_now
    |=> st.ctrl[`TMR_CTRL_IE0] && ext_irq_zero_req)
    else $error("external edge not flagged");
  AST_GATE: assert property (
    st.mode[`TMR_MODE_TIMER_ZERO_GATE] && !ext_irq_zero_pin && !split && !wr_now |=> $stable(st.cnt0))
    else $error("gated timer 0 counted with pin low");
  AST_RUN_OFF: assert property (
    !st.ctrl[`TMR_CTRL_TR0] && !split && !wr_now |=> $stable(st.cnt0))
    else $error("timer 0 counted while stopped");
  AST_WB_ACK: assert property (
    wb_cyc_i && wb_stb_i && !st.ack |=> st.ack ##1 !st.ack)
    else $error("bus ack not a single cycle after request");
  AST_T1_SPLIT_RUN: assert property (
    split && md1 == TMR_RELOAD16 && !st.mode[`TMR_MODE_GATE1] && !st.mode[`TMR_MODE_SEL1]
    && tk.tick && st.cnt1 != `TMR_CNT16_MAX && !wr_now
    |=> st.cnt1 == $past(st.cnt1) + 16'h0001)
    else $error("timer 1 did not run while timer 0 split");
  AST_T1_VEC_CLEAR: assert property (
    irq_vec_t1 && !(split ? ovf_hi : ovf1) && !wr_now |=> !st.ctrl[`TMR_CTRL_TF1])
    else $error("vector did not clear timer 1 flag");
  AST_EXT1_EDGE: assert property (
    st.ctrl[`TMR_CTRL_IT1] && st.pin_prev[1] && !ext_irq_one_pin && !wr_now
    |=> st.ctrl[`TMR_CTRL_IE1] && ext_irq_one_req)
    else $error("external edge one not flagged");
  AST_TOE1_SUPPRESS: assert property (
    $rose(st.ctrl[`TMR_CTRL_TF1]) |-> $past(!st.ostat[`TMR_OSTAT_TOE1] || wr_now))
    else $error("timer 1 flag set while toggle output enabled");
  AST_EXT_LEVEL: assert property (
    !st.ctrl[`TMR_CTRL_IT0] && !wr_now |=> ext_irq_zero_req == !$past(ext_irq_zero_pin))
    else $error("level request does not follow the pin");
  AST_COUNT_PIN: assert property (
    st.ctrl[`TMR_CTRL_TR0] && st.mode[`TMR_MODE_SEL0] && md0 == TMR_FREE16
    && (!st.mode[`TMR_MODE_TIMER_ZERO_GATE] || ext_irq_zero_pin) && tk.pin_fall[0] && !wr_now
    |=> st.cnt0 == $past(st.cnt0) + 16'h0001)
    else $error("counter mode missed a pin edge");

  COV_RELOAD16: cover property (inc0 && md0 == TMR_RELOAD16 && s0[16]);
  COV_RELOAD8: cover property (inc1 && md1 == TMR_RELOAD8 && s1[16]);
  COV_SPLIT_HIGH: cover property (ovf_hi);
  COV_EXT_EDGE: cover property ($rose(st.ctrl[`TMR_CTRL_IE1]));
  COV_SPLIT_T1_RUN: cover property (split && inc1);
endmodule : tmr_dual_timer

//--- bench/tmr_pin_model.sv
/*
  Far-side model of the count pins and the interrupt/gate pins.
  Assumes pull-ups, so every pin idles high, and pins change only
  right after a rising clk_sys edge.
*/
`timescale 1ns/1ps
module tmr_pin_model (
  // Clock
  input wire logic clk_sys,
  // Pins
  output logic t0_count_pin,
  output logic t1_count_pin,
  output logic ext_irq_zero_pin,
  output logic ext_irq_one_pin
);
  // Order: t0 count, t1 count, irq zero, irq one
  logic [3:0] pins = 4'hf;
  assign {ext_irq_one_pin, ext_irq_zero_pin, t1_count_pin, t0_count_pin} = pins;

  task set_pin(input int idx, input logic val);
    @(posedge clk_sys);
    pins[idx] <= val;
  endtask : set_pin

  // Hold of 2 is the fastest legal rate, larger is a slow source
  task pulse(input int idx, input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      set_pin(idx, 1'b0);
      repeat (hold - 1) @(posedge clk_sys);
      set_pin(idx, 1'b1);
      repeat (hold - 1) @(posedge clk_sys);
    end
  endtask : pulse
endmodule : tmr_pin_model

//--- bench/tb_top.sv
/*
  Self-checking bench of the dual timer/counter.
  Assumes the design core on a 200 MHz clk_sys and the pin model as partner.
*/
`timescale 1ns/1ps
`include "tmr_defines.svh"
module tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd_o;
  logic [31:0] rdat;
  logic ack;
  logic [3:0] vec = 4'h0;
  logic tf0, tf1, req0, req1, baud, tbase;
  logic t0p, t1p, e0p, e1p;
  logic [2:0] watch;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int a, b, s;

  assign watch = {baud, tf1, tf0};
  always #2.5 clk_sys = ~clk_sys;

  tmr_dual_timer tmr_dual_timer_i (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
    .wb_dat_o(rd_o), .wb_ack_o(ack), .t0_count_pin(t0p), .t1_count_pin(t1p),
    .ext_irq_zero_pin(e0p), .ext_irq_one_pin(e1p), .irq_vec_t0(vec[0]),
    .irq_vec_t1(vec[1]), .irq_vec_ext0(vec[2]), .irq_vec_ext1(vec[3]),
    .timer_zero_overflow_flag(tf0), .timer_one_overflow_flag(tf1),
    .ext_irq_zero_req(req0), .ext_irq_one_req(req1), .t1_baud_tick(baud),
    .tbase_tick(tbase));
  tmr_pin_model tmr_pin_model_i (.clk_sys(clk_sys), .t0_count_pin(t0p),
    .t1_count_pin(t1p), .ext_irq_zero_pin(e0p), .ext_irq_one_pin(e1p));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task wb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1);
    rdat = rd_o;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task wr(input logic [11:0] ad, input logic [31:0] d);
    wb(1'b1, ad, d);
  endtask : wr

  task rd(input logic [11:0] ad);
    wb(1'b0, ad, 32'h0);
  endtask : rd

  task pulse_vec(input int i);
    @(posedge clk_sys);
    vec[i] <= 1'b1;
    @(posedge clk_sys);
    vec[i] <= 1'b0;
  endtask : pulse_vec

  task wait_sig(input int which, output int at);
    at = -1;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk_sys);
      #1;
      if (watch[which] === 1'b1) begin
        at = cycles;
        break;
      end
    end
    check({31'h0, watch[which]}, 32'h1);
  endtask : wait_sig

  task setup(input logic [7:0] sc, input logic [7:0] md, input logic [15:0] rl,
             input logic [15:0] cn, input int t);
    wr(`TMR_OFS_CTRL, 32'h0);
    wr(`TMR_OFS_OSTAT, 32'h0);
    wr(`TMR_OFS_SCFG, {24'h0, sc});
    wr(`TMR_OFS_MODE, {24'h0, md});
    wr(t ? `TMR_OFS_RLD1 : `TMR_OFS_RLD0, {16'h0, rl});
    wr(t ? `TMR_OFS_CNT1 : `TMR_OFS_CNT0, {16'h0, cn});
  endtask : setup

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_regs;
    int n;
    rd(`TMR_OFS_CTRL);
    check(rdat, 32'h0);
    rd(12'h430);
    check(rdat, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(`TMR_OFS_SCFG, 32'(c << 2));
      n = 0;
      repeat (64) begin
        @(posedge clk_sys);
        #1;
        if (tbase === 1'b1) n++;
      end
      check(32'(n), (c == 3) ? 32'h0 : 32'(64 >> (2 * c + 2)));
    end
    wr(`TMR_OFS_SCFG, 32'hff);
    rd(`TMR_OFS_SCFG);
    check(rdat, 32'h0f);
    $display("test regs done");
  endtask : t_regs

  task t_mode0;
    setup(8'h00, 8'h00, 16'hfffe, 16'hfffe, 0);
    wr(`TMR_OFS_CTRL, 32'h10);
    wait_sig(0, a);
    pulse_vec(0);
    wait_sig(0, b);
    check(32'(b - a), 32'h8);
    wr(`TMR_OFS_OSTAT, 32'h01);
    wr(`TMR_OFS_CTRL, 32'h10);
    repeat (40) @(posedge clk_sys);
    check({31'h0, tf0}, 32'h0);
    $display("test mode0 done");
  endtask : t_mode0

  task t_mode2;
    setup(8'h04, 8'h20, 16'h5af0, 16'h5af0, 0);
    wr(`TMR_OFS_CTRL, 32'h10);
    wait_sig(0, a);
    pulse_vec(0);
    wait_sig(0, b);
    check(32'(b - a), 32'h100);
    wr(`TMR_OFS_CTRL, 32'h0);
    rd(`TMR_OFS_CNT0);
    check({24'h0, rdat[15:8]}, 32'h5a);
    $display("test mode2 done");
  endtask : t_mode2

  task t_mode1;
    setup(8'h00, 8'h01, 16'h1234, 16'hfffe, 1);
    wr(`TMR_OFS_CTRL, 32'h40);
    wait_sig(1, a);
    rd(`TMR_OFS_CTRL);
    check(rdat, 32'hc0);
    pulse_vec(1);
    @(posedge clk_sys);
    check({31'h0, tf1}, 32'h0);
    wr(`TMR_OFS_CTRL, 32'h0);
    rd(`TMR_OFS_CNT1);
    check({24'h0, rdat[15:8]}, 32'h0);
    wr(`TMR_OFS_MODE, 32'h03);
    wr(`TMR_OFS_CTRL, 32'h40);
    rd(`TMR_OFS_CNT1);
    s = int'(rdat);
    repeat (40) @(posedge clk_sys);
    rd(`TMR_OFS_CNT1);
    check(rdat, 32'(s));
    wr(`TMR_OFS_OSTAT, 32'h04);
    wr(`TMR_OFS_CNT1, 32'hfffe);
    wr(`TMR_OFS_MODE, 32'h01);
    wait_sig(2, a);
    repeat (2) @(posedge clk_sys);
    check({31'h0, tf1}, 32'h0);
    $display("test mode1 done");
  endtask : t_mode1

  task t_split;
    setup(8'h00, 8'h30, 16'h0000, 16'hfe00, 0);
    wr(`TMR_OFS_CTRL, 32'h40);
    wait_sig(1, a);
    rd(`TMR_OFS_CTRL);
    check(rdat, 32'hc0);
    rd(`TMR_OFS_CNT0);
    check({24'h0, rdat[7:0]}, 32'h0);
    wr(`TMR_OFS_CTRL, 32'h0);
    rd(`TMR_OFS_CNT1);
    s = int'(rdat);
    repeat (41) @(posedge clk_sys);
    rd(`TMR_OFS_CNT1);
    check(rdat - 32'(s), 32'hb);
    $display("test split done");
  endtask : t_split

  task t_count;
    setup(8'h00, 8'hd0, 16'h0000, 16'h0000, 0);
    tmr_pin_model_i.set_pin(2, 1'b0);
    wr(`TMR_OFS_CTRL, 32'h10);
    check({31'h0, req0}, 32'h1);
    tmr_pin_model_i.pulse(0, 3, 2);
    repeat (6) @(posedge clk_sys);
    rd(`TMR_OFS_CNT0);
    check(rdat, 32'h0);
    tmr_pin_model_i.set_pin(2, 1'b1);
    tmr_pin_model_i.pulse(0, 5, 3);
    repeat (6) @(posedge clk_sys);
    rd(`TMR_OFS_CNT0);
    check(rdat, 32'h5);
    $display("test count done");
  endtask : t_count

  task t_ext;
    for (int i = 0; i < 2; i++) begin
      wr(`TMR_OFS_CTRL, 32'(1 << (2 * i)));
      tmr_pin_model_i.set_pin(2 + i, 1'b0);
      repeat (4) @(posedge clk_sys);
      check({31'h0, i ? req1 : req0}, 32'h1);
      rd(`TMR_OFS_CTRL);
      check(rdat, 32'(3 << (2 * i)));
      tmr_pin_model_i.set_pin(2 + i, 1'b1);
      pulse_vec(2 + i);
      rd(`TMR_OFS_CTRL);
      check(rdat, 32'(1 << (2 * i)));
    end
    $display("test ext done");
  endtask : t_ext

  // ----------------------------------------------------------------------
  // Main sequence and timeout
  // ----------------------------------------------------------------------
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_mode0();
    t_mode2();
    t_mode1();
    t_split();
    t_count();
    t_ext();
    end_sim();
  end
endmodule : tb_top
